// [design/tcc_continue_ctrl.sv]
// Continue control: decides per ten-word group whether an operation goes on
// How it works
// - continue set by either instruction, cleared at group start
// - beyond-gap flag set only by beyond-gap instruction
// - native read: beyond-gap only during last blockette
// - beyond-gap cleared at write gap or non-terminal read gap
// - read group end without continue sets check-read
// - group end also sets continue-check, clears beyond-gap
// - instruction with continue-check set raises error
// - beyond-gap flag inhibits read ending logic
// - continue flag blocks check-read and continue-check gate
// - read terminates at group only before a gap
// - read error clears both continue flags
// - started check-read runs to block end
// - check-read error clears flags, ends at block
// - write without continue sets check after ninth word
// - continue-check alerts write ending after tenth word
// - no continue stops memory request after tenth fetch
// - late instruction in write gives continue-check error
// - early beyond-gap in write inserts gap after tenth
// - write error clears flags; tenth-word error ends later
// - continue-check error sets shared error and indicator
`timescale 1ns/1ns
module tcc_continue_ctrl
   import tcc_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst_b,
   input wire logic i_enable,
   input wire logic i_op_start,
   input wire logic i_op_read,
   input wire logic i_op_check_read,
   input wire logic i_op_write,
   input wire logic i_op_end,
   input wire logic i_native_format,
   input wire logic i_continue_instr,
   input wire logic i_continue_beyond_gap_instr,
   input wire logic i_group_first_digit,
   input wire logic i_last_blockette_signal,
   input wire logic i_write_gap_start_signal,
   input wire logic i_read_gap_detect_signal,
   input wire logic i_terminal_gap,
   input wire logic i_gap_follows_group,
   input wire logic i_group_end_no_continue_signal,
   input wire logic i_block_end,
   input wire logic i_write_ninth_word_done,
   input wire logic i_write_tenth_fetched,
   input wire logic i_error_event,
   input wire logic i_error_clear,
   output logic o_continue,
   output logic o_continue_beyond_gap,
   output logic o_continue_check,
   output logic o_read_write_error,
   output logic o_continue_check_error,
   output logic o_diag_indicator_5,
   output logic o_check_read,
   output logic o_read_end_inhibit,
   output logic o_read_end_at_block,
   output logic o_write_end_alert,
   output logic o_write_gap_alert,
   output logic o_mem_request_block
);
   tcc_flag_if flags ();

   // Sets win over clears unless the terms below force them off
   tcc_flag_bank u_flag_bank (
      .i_clock(i_clock),
      .i_rst_b(i_rst_b),
      .i_enable(i_enable),
      .flags(flags)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Operation state
   tcc_op_type op_q;
   tcc_op_type op_d;
   logic check_read_q;
   logic check_read_d;
   logic diag_q;
   logic diag_d;
   logic cce_q;
   logic cce_d;
   logic tenth_err_q;
   logic tenth_err_d;

   logic cont;
   logic gap;
   logic check;
   logic err;
   logic any_instr;
   logic in_read;
   logic beyond_allowed;
   logic group_gate;
   logic cc_error;
   // Decoded terms, one per set or clear cause
   logic is_idle;
   logic is_read;
   logic is_check_read;
   logic is_write;
   logic instr_ok;
   logic set_cont;
   logic set_gap;
   logic clr_cont_group;
   logic clr_gap_write;
   logic clr_gap_read;
   logic clr_gap_check;
   logic set_check_read;
   logic set_check_write;
   logic set_err;
   logic read_err_group;
   logic write_tenth_err;

   assign cont = flags.q[FLAG_CONTINUE];
   assign gap = flags.q[FLAG_BEYOND_GAP];
   assign check = flags.q[FLAG_CHECK];
   assign err = flags.q[FLAG_ERROR];
   assign any_instr = i_continue_instr | i_continue_beyond_gap_instr;
   assign is_idle = (op_q == TCC_IDLE);
   assign is_read = (op_q == TCC_READ);
   assign is_check_read = (op_q == TCC_CHECK_READ);
   assign is_write = (op_q == TCC_WRITE);
   assign in_read = is_read | is_check_read;

   ////////////////////////////////////////////////////////////////////////////
   // Decoded set and clear conditions
   // An instruction while idle or after continue-check is refused
   assign cc_error = any_instr & (is_idle | check);
   // Refused instructions set neither continue flag
   assign instr_ok = !cc_error & !err;
   assign beyond_allowed = !(in_read & i_native_format) | i_last_blockette_signal;
   assign set_cont = any_instr & instr_ok;
   assign set_gap = i_continue_beyond_gap_instr & instr_ok & beyond_allowed;
   assign clr_cont_group = i_group_first_digit;
   assign clr_gap_write = is_write & i_write_gap_start_signal;
   assign clr_gap_read = in_read & i_read_gap_detect_signal & !i_terminal_gap;
   assign clr_gap_check = check;
   // Only a plain read turns its tail into a check-read
   assign group_gate = is_read & i_group_end_no_continue_signal & !cont;
   // In the first error cycle the continue flag may still stand
   assign read_err_group = err & is_read & i_group_end_no_continue_signal;
   assign set_check_read = group_gate;
   assign set_check_write = is_write & i_write_ninth_word_done & !cont;
   assign set_err = cc_error | (i_error_event & !is_idle);
   assign write_tenth_err = is_write & i_error_event & i_write_ninth_word_done;

   ////////////////////////////////////////////////////////////////////////////
   // Flag set and clear terms
   always_comb begin
      flags.set = '0;
      flags.clr = '0;
      if (set_cont) begin
         flags.set[FLAG_CONTINUE] = 1'b1;
      end
      if (set_gap) begin
         flags.set[FLAG_BEYOND_GAP] = 1'b1;
      end
      if (clr_cont_group) begin
         flags.clr[FLAG_CONTINUE] = 1'b1;
      end
      if (clr_gap_write) begin
         flags.clr[FLAG_BEYOND_GAP] = 1'b1;
      end
      if (clr_gap_read) begin
         flags.clr[FLAG_BEYOND_GAP] = 1'b1;
      end
      if (set_check_read) begin
         flags.set[FLAG_CHECK] = 1'b1;
      end
      if (set_check_write) begin
         flags.set[FLAG_CHECK] = 1'b1;
      end
      if (clr_gap_check) begin
         flags.clr[FLAG_BEYOND_GAP] = 1'b1;
      end
      if (set_err) begin
         flags.set[FLAG_ERROR] = 1'b1;
      end
      // A standing error keeps both continue flags down
      if (err) begin
         flags.clr[FLAG_CONTINUE] = 1'b1;
         flags.clr[FLAG_BEYOND_GAP] = 1'b1;
         flags.set[FLAG_CONTINUE] = 1'b0;
         flags.set[FLAG_BEYOND_GAP] = 1'b0;
      end
      if (i_error_clear) begin
         flags.clr[FLAG_ERROR] = 1'b1;
      end
      // A new operation overrides every set but the error set made in the same cycle
      if (i_op_start) begin
         flags.set[FLAG_CONTINUE] = 1'b0;
         flags.set[FLAG_BEYOND_GAP] = 1'b0;
         flags.set[FLAG_CHECK] = 1'b0;
         flags.clr[FLAG_CONTINUE] = 1'b1;
         flags.clr[FLAG_BEYOND_GAP] = 1'b1;
         flags.clr[FLAG_CHECK] = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Operation tracking
   always_comb begin
      op_d = op_q;
      check_read_d = check_read_q;
      tenth_err_d = tenth_err_q;
      if (group_gate | read_err_group) begin
         check_read_d = 1'b1;
      end
      if (is_write & i_group_first_digit) begin
         tenth_err_d = 1'b0;
      end
      // An error in the tenth word postpones the end by one group
      if (write_tenth_err) begin
         tenth_err_d = 1'b1;
      end
      if (i_op_end) begin
         op_d = TCC_IDLE;
         check_read_d = 1'b0;
         tenth_err_d = 1'b0;
      end
      if (i_op_start) begin
         check_read_d = i_op_check_read;
         tenth_err_d = 1'b0;
         case ({i_op_write, i_op_check_read, i_op_read})
            3'h1: begin
               op_d = TCC_READ;
            end
            3'h2: begin
               op_d = TCC_CHECK_READ;
            end
            3'h4: begin
               op_d = TCC_WRITE;
            end
            default: begin
               op_d = TCC_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         op_q <= TCC_IDLE;
         check_read_q <= 1'b0;
         tenth_err_q <= 1'b0;
      end else if (i_enable) begin
         op_q <= op_d;
         check_read_q <= check_read_d;
         tenth_err_q <= tenth_err_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Error report: one-cycle error pulse and sticky indicator
   always_comb begin
      diag_d = diag_q;
      cce_d = cc_error;
      if (i_error_clear) begin
         diag_d = 1'b0;
      end
      // A bad instruction in the clearing cycle still leaves its mark
      if (cc_error) begin
         diag_d = 1'b1;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         diag_q <= 1'b0;
         cce_q <= 1'b0;
      end else if (i_enable) begin
         diag_q <= diag_d;
         cce_q <= cce_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs to read, write and buffer logic
   assign o_continue = cont;
   assign o_continue_beyond_gap = gap;
   assign o_continue_check = check;
   assign o_read_write_error = err;
   assign o_continue_check_error = cce_q;
   assign o_diag_indicator_5 = diag_q;
   assign o_check_read = check_read_q;
   logic read_end_inhibit;
   logic read_end_at_block;
   logic write_end_alert;
   logic write_gap_alert;
   logic mem_request_block;

   // Alerts stay combinational so the far side sees them in the same cycle
   assign read_end_inhibit = in_read & gap;
   // Ending only at a group that is followed by a gap
   assign read_end_at_block = in_read & !gap & i_gap_follows_group
      & (check_read_q | check);
   assign write_end_alert = is_write & check & !tenth_err_q;
   assign write_gap_alert = is_write & gap;
   assign mem_request_block = is_write & !cont & i_write_tenth_fetched;
   assign o_read_end_inhibit = read_end_inhibit;
   assign o_read_end_at_block = read_end_at_block;
   assign o_write_end_alert = write_end_alert;
   assign o_write_gap_alert = write_gap_alert;
   assign o_mem_request_block = mem_request_block;
endmodule : tcc_continue_ctrl

// [design/tcc_flag_bank.sv]
// Bank of sticky flags where a set wins over a simultaneous clear
`timescale 1ns/1ns
module tcc_flag_bank
   import tcc_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst_b,
   input wire logic i_enable,
   tcc_flag_if.bank flags
);
   logic [FLAG_COUNT-1:0] flag_q;
   logic [FLAG_COUNT-1:0] flag_d;

   genvar g;
   generate
      for (g = 0; g < FLAG_COUNT; g++) begin : g_flag
         always_comb begin
            flag_d[g] = flag_q[g];
            if (flags.clr[g]) begin
               flag_d[g] = 1'b0;
            end
            if (flags.set[g]) begin
               flag_d[g] = 1'b1;
            end
         end
      end
   endgenerate

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         flag_q <= {FLAG_COUNT{RESET_FLAG_VALUE}};
      end else if (i_enable) begin
         flag_q <= flag_d;
      end
   end

   assign flags.q = flag_q;
endmodule : tcc_flag_bank

// [design/tcc_flag_if.sv]
// Interface carrying flag set and clear requests to the flag bank
`timescale 1ns/1ns
interface tcc_flag_if;
   import tcc_pkg::*;
   logic [FLAG_COUNT-1:0] set;
   logic [FLAG_COUNT-1:0] clr;
   logic [FLAG_COUNT-1:0] q;
   modport ctrl (output set, output clr, input q);
   modport bank (input set, input clr, output q);
endinterface : tcc_flag_if

// [design/tcc_pkg.sv]
// Package of constants and types for the tape continue control block
package tcc_pkg;
   localparam logic RESET_FLAG_VALUE = 1'b0;
   localparam int FLAG_COUNT = 4;
   localparam int FLAG_CONTINUE = 0;
   localparam int FLAG_BEYOND_GAP = 1;
   localparam int FLAG_CHECK = 2;
   localparam int FLAG_ERROR = 3;

   typedef enum logic [1:0] {
      TCC_IDLE,
      TCC_READ,
      TCC_CHECK_READ,
      TCC_WRITE
   } tcc_op_type;
endpackage : tcc_pkg

// [dv/tb_top.sv]
// Self-checking bench for the continue control block
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
   $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tb_top;
   logic i_clock = 1'b0;
   logic i_rst_b = 1'b0;
   logic [8:0] pv = 9'h000;
   logic [2:0] op_t = 3'h0;
   logic nat = 1'b0, blk = 1'b0, tg = 1'b0, gf = 1'b0, tf = 1'b0, slow = 1'b0;
   logic [1:0] req = 2'h0;
   logic en = 1'b1;
   wire logic ci, cbi;
   wire logic [11:0] o;
   int error_cnt = 0, n_compared = 0, cyc = 0;
   initial forever #20 i_clock = ~i_clock;
   tcc_proc_model proc (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_req(req), .i_slow(slow),
      .o_continue_instr(ci), .o_continue_beyond_gap_instr(cbi));
   tcc_continue_ctrl dut (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_enable(en),
      .i_op_start(pv[0]), .i_op_read(op_t[2]), .i_op_check_read(op_t[1]), .i_op_write(op_t[0]),
      .i_op_end(pv[1]), .i_native_format(nat), .i_continue_instr(ci),
      .i_continue_beyond_gap_instr(cbi), .i_group_first_digit(pv[2]),
      .i_last_blockette_signal(blk), .i_write_gap_start_signal(pv[3]),
      .i_read_gap_detect_signal(pv[4]), .i_terminal_gap(tg), .i_gap_follows_group(gf),
      .i_group_end_no_continue_signal(pv[5]), .i_block_end(1'b0),
      .i_write_ninth_word_done(pv[6]), .i_write_tenth_fetched(tf), .i_error_event(pv[7]),
      .i_error_clear(pv[8]), .o_continue(o[0]), .o_continue_beyond_gap(o[1]),
      .o_continue_check(o[2]), .o_read_write_error(o[3]), .o_continue_check_error(o[4]),
      .o_diag_indicator_5(o[5]), .o_check_read(o[6]), .o_read_end_inhibit(o[7]),
      .o_read_end_at_block(o[8]), .o_write_end_alert(o[9]), .o_write_gap_alert(o[10]),
      .o_mem_request_block(o[11]));
   task pulse(input logic [8:0] v);
      @(posedge i_clock) pv <= v;
      @(posedge i_clock) pv <= 9'h000;
      #1;
   endtask : pulse
   task op(input logic [2:0] t);
      @(posedge i_clock) op_t <= t;
      pulse(9'h001);
   endtask : op
   // Instruction through the processor model; flags are read once it has landed
   task ins(input logic [1:0] k, input logic s);
      @(posedge i_clock) begin req <= k; slow <= s; end
      @(posedge i_clock) req <= 2'h0;
      repeat (s ? 2 : 1) @(posedge i_clock);
      #1;
   endtask : ins
   task end_sim;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_sim
   always @(posedge i_clock) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         end_sim();
      end
   end
   initial begin
      repeat (12) @(posedge i_clock);
      i_rst_b <= 1'b1;
      op(3'h1);
      ins(2'h1, 1'b0);
      `CHK("cont", 1'b1, o[0])
      `CHK("gap", 1'b0, o[1])
      pulse(9'h004);
      `CHK("cont", 1'b0, o[0])
      @(posedge i_clock) tf <= 1'b1;
      pulse(9'h040);
      `CHK("check", 1'b1, o[2])
      `CHK("end_alert", 1'b1, o[9])
      `CHK("mem_block", 1'b1, o[11])
      ins(2'h1, 1'b1);
      `CHK("chk_err", 1'b1, o[4])
      `CHK("diag", 1'b1, o[5])
      `CHK("rw_err", 1'b1, o[3])
      pulse(9'h100);
      $display("test write_end done");
      op(3'h1);
      `CHK("check", 1'b0, o[2])
      ins(2'h2, 1'b1);
      `CHK("gap", 1'b1, o[1])
      `CHK("gap_alert", 1'b1, o[10])
      `CHK("mem_block", 1'b0, o[11])
      pulse(9'h040);
      `CHK("check", 1'b0, o[2])
      pulse(9'h008);
      `CHK("gap", 1'b0, o[1])
      pulse(9'h004);
      pulse(9'h0C0);
      `CHK("end_alert", 1'b0, o[9])
      `CHK("check", 1'b1, o[2])
      `CHK("rw_err", 1'b1, o[3])
      pulse(9'h100);
      $display("test write_gap done");
      @(posedge i_clock) begin nat <= 1'b1; tf <= 1'b0; end
      op(3'h4);
      ins(2'h2, 1'b0);
      `CHK("gap", 1'b0, o[1])
      @(posedge i_clock) blk <= 1'b1;
      ins(2'h2, 1'b0);
      `CHK("gap", 1'b1, o[1])
      `CHK("inhibit", 1'b1, o[7])
      pulse(9'h020);
      `CHK("check_read", 1'b0, o[6])
      pulse(9'h004);
      @(posedge i_clock) gf <= 1'b1;
      pulse(9'h020);
      `CHK("check_read", 1'b1, o[6])
      `CHK("check", 1'b1, o[2])
      @(posedge i_clock) #1;
      `CHK("gap", 1'b0, o[1])
      `CHK("at_block", 1'b1, o[8])
      ins(2'h1, 1'b0);
      `CHK("chk_err", 1'b1, o[4])
      pulse(9'h100);
      $display("test read_end done");
      op(3'h4);
      ins(2'h2, 1'b0);
      @(posedge i_clock) tg <= 1'b1;
      pulse(9'h010);
      `CHK("gap", 1'b1, o[1])
      @(posedge i_clock) tg <= 1'b0;
      pulse(9'h010);
      `CHK("gap", 1'b0, o[1])
      pulse(9'h080);
      @(posedge i_clock) #1;
      `CHK("cont", 1'b0, o[0])
      pulse(9'h100);
      op(3'h2);
      ins(2'h2, 1'b1);
      pulse(9'h080);
      @(posedge i_clock) #1;
      `CHK("gap", 1'b0, o[1])
      `CHK("cont", 1'b0, o[0])
      pulse(9'h100);
      pulse(9'h002);
      ins(2'h1, 1'b0);
      `CHK("rw_err", 1'b1, o[3])
      @(posedge i_clock) en <= 1'b0;
      pulse(9'h100);
      `CHK("rw_err", 1'b1, o[3])
      @(posedge i_clock) en <= 1'b1;
      pulse(9'h100);
      `CHK("rw_err", 1'b0, o[3])
      $display("test errors done");
      end_sim();
   end
endmodule : tb_top

// [dv/tcc_monitor.sv]
// Checker of the continue flags at the block ports
`timescale 1ns/1ns
module tcc_monitor (
   input wire logic i_clock,
   input wire logic i_rst_b,
   input wire logic i_enable,
   input wire logic i_op_start,
   input wire logic i_continue_instr,
   input wire logic i_continue_beyond_gap_instr,
   input wire logic i_group_first_digit,
   input wire logic i_group_end_no_continue_signal,
   input wire logic o_continue,
   input wire logic o_continue_beyond_gap,
   input wire logic o_continue_check,
   input wire logic o_read_write_error,
   input wire logic o_continue_check_error,
   input wire logic o_diag_indicator_5
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_b);
   wire logic ins = i_continue_instr || i_continue_beyond_gap_instr;
   cont_rise_a: assert property ($rose(o_continue) |-> $past(ins))
      else $error("continue rose alone");
   gap_rise_a: assert property ($rose(o_continue_beyond_gap) |-> $past(i_continue_beyond_gap_instr))
      else $error("beyond gap rose alone");
   cont_clear_a: assert property (i_enable && i_group_first_digit && !ins |=> !o_continue)
      else $error("continue kept at group");
   late_instr_a: assert property (i_enable && ins && o_continue_check && !o_read_write_error
      && !i_op_start |=> o_continue_check_error)
      else $error("no continue check error");
   err_diag_a: assert property (o_continue_check_error |-> o_read_write_error && o_diag_indicator_5)
      else $error("error flags missing");
   err_clears_a: assert property (o_read_write_error && $past(o_read_write_error)
      |-> !o_continue && !o_continue_beyond_gap)
      else $error("flags kept on error");
   start_clears_a: assert property (i_enable && i_op_start
      |=> !o_continue && !o_continue_beyond_gap && !o_continue_check)
      else $error("flags kept on start");
   cont_blocks_a: assert property (i_enable && o_continue && !o_continue_check && !i_op_start
      && i_group_end_no_continue_signal |=> !o_continue_check)
      else $error("check set despite continue");
endmodule : tcc_monitor
bind tcc_continue_ctrl tcc_monitor mon (.i_clock, .i_rst_b, .i_enable, .i_op_start,
   .i_continue_instr, .i_continue_beyond_gap_instr, .i_group_first_digit,
   .i_group_end_no_continue_signal, .o_continue, .o_continue_beyond_gap, .o_continue_check,
   .o_read_write_error, .o_continue_check_error, .o_diag_indicator_5);

// [dv/tcc_proc_model.sv]
// Processor model that issues continue instructions on request
`timescale 1ns/1ns
module tcc_proc_model (
   input wire logic i_clock,
   input wire logic i_rst_b,
   input wire logic [1:0] i_req,
   input wire logic i_slow,
   output logic o_continue_instr,
   output logic o_continue_beyond_gap_instr
);
   logic [1:0] now_q;
   logic [1:0] late_q;
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         now_q <= 2'h0;
         late_q <= 2'h0;
      end else begin
         now_q <= i_req;
         late_q <= now_q;
      end
   end
   // Slow answers model a program that takes longer to decide
   assign o_continue_instr = i_slow ? late_q[0] : now_q[0];
   assign o_continue_beyond_gap_instr = i_slow ? late_q[1] : now_q[1];
endmodule : tcc_proc_model
